// >>> pcap1_asserts.sv
/*
  Checker for the capture input one block, bound to pcap1_top.
  Assumes one clock, reset active high, read answers one cycle late.
*/
`timescale 1ns/1ps
`include "pcap1_cfg.svh"

module pcap1_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Capture side
  input wire logic cap_pin,
  input wire logic cap_enable,
  input wire logic frame_shift,
  input wire logic cap_event,
  // Read port
  input wire logic rd_req,
  input wire pcap1_pkg::pcap1_addr_t rd_addr,
  input wire pcap1_pkg::pcap1_data_t rd_data,
  input wire logic rd_valid,
  input wire logic rd_err
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic mapped;

  // Address decode kept apart from the design's own
  assign mapped = rd_addr inside {`PCAP1_ADDR_POS, `PCAP1_ADDR_TOTAL,
    `PCAP1_ADDR_SNAP_CNT, `PCAP1_ADDR_SNAP_POS, `PCAP1_ADDR_RISE_CNT,
    `PCAP1_ADDR_FALL_CNT, `PCAP1_ADDR_POS_RISE, `PCAP1_ADDR_POS_FALL};

  // A read with no frame shift; q narrows it further
  sequence s_rd(a, q);
    rd_req && rd_addr == a && !frame_shift && q;
  endsequence

  ////////////////////////////////
  AST_RD_ANSWER: assert property (rd_req |=> rd_valid)
    else $error("read not answered next cycle");
  AST_RD_IDLE: assert property (!rd_req |=> !rd_valid && rd_data == '0)
    else $error("read port active without request");
  AST_RD_MAP: assert property (rd_req |=> rd_err == !$past(mapped))
    else $error("error flag wrong for address");
  AST_ERR_ZERO: assert property (rd_err |-> rd_valid && rd_data == '0)
    else $error("error answer carries data");
  AST_EN_GATE: assert property (
    !cap_enable || $rose(cap_enable) |=> !cap_event)
    else $error("event while inactive or activating");
  AST_EVT_SPACE: assert property (cap_event |=> !cap_event)
    else $error("two events in adjacent cycles");
  AST_EVT_PIN: assert property (
    cap_event |-> $past(cap_pin, 4) != $past(cap_pin, 6))
    else $error("event without pin edge");
  AST_SNAP_HOLD: assert property (
    s_rd(`PCAP1_ADDR_SNAP_POS, 1'b1) ##1 s_rd(`PCAP1_ADDR_SNAP_POS, 1'b1)
    |=> rd_data == $past(rd_data))
    else $error("snapshot moved without count read");
  AST_SNAP_PAIR: assert property (
    s_rd(`PCAP1_ADDR_POS, !cap_event) ##1
    s_rd(`PCAP1_ADDR_SNAP_CNT, !cap_event) ##1
    s_rd(`PCAP1_ADDR_SNAP_POS, !cap_event) |=> rd_data == $past(rd_data, 2))
    else $error("snapshot differs from position");
endmodule : pcap1_chk

bind pcap1_top pcap1_chk pcap1_chk_i (.clk(clk), .rst(rst),
  .cap_pin(cap_pin), .cap_enable(cap_enable), .frame_shift(frame_shift),
  .cap_event(cap_event), .rd_req(rd_req), .rd_addr(rd_addr),
  .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err));

// >>> pcap1_cfg.svh
/*
  Constants for the capture input one block: parameter addresses,
  widths and reset values, all as macros.
  Assumes it is included by bare name from the package and the modules.
*/
// Overview of operation
// - Count capture events caused by falling edges, unsigned 16 bit.
// - Count capture events caused by rising edges, unsigned 16 bit.
// - Count every capture event, whatever its edge, unsigned 16 bit.
// - Activating the capture input clears all event counters to zero.
// - Each capture latches actual motor position into signed 32-bit register.
// - Position setting or reference move shifts stored positions too.
// - Reading snapshot counter copies captured into snapshot position.
// - Snapshot position ignores captures until next snapshot count read.
// - Keep separate positions latched at last rising and last falling edge.
`ifndef PCAP1_CFG_SVH
`define PCAP1_CFG_SVH

////////////////////////////////////////////////////////////////////////
// Widths
`define PCAP1_ADDR_W 16
`define PCAP1_DATA_W 32
`define PCAP1_CNT_W 16
`define PCAP1_POS_W 32

////////////////////////////////////////////////////////////////////////
// Parameter addresses, as printed
`define PCAP1_ADDR_POS 16'h0a0c
`define PCAP1_ADDR_TOTAL 16'h0a10
`define PCAP1_ADDR_SNAP_CNT 16'h0a2e
`define PCAP1_ADDR_SNAP_POS 16'h0a30
`define PCAP1_ADDR_RISE_CNT 16'h0a56
`define PCAP1_ADDR_FALL_CNT 16'h0a58
`define PCAP1_ADDR_POS_RISE 16'h0a4a
`define PCAP1_ADDR_POS_FALL 16'h0a4c

////////////////////////////////////////////////////////////////////////
// Reset values and the counter step
`define PCAP1_CNT_RST 16'h0000
`define PCAP1_POS_RST 32'h0000_0000
`define PCAP1_DATA_RST 32'h0000_0000
`define PCAP1_CNT_ONE 16'h0001

`endif

// >>> pcap1_edge.sv
/*
  Synchroniser and edge detector for the capture pin.
  Assumes the pin is asynchronous to clk; outputs are one-cycle pulses.
*/
`timescale 1ns/1ps

module pcap1_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw capture pin
  input wire logic pin,
  // Edge pulses
  output logic rise,
  output logic fall
);

  logic sync1_q, sync1_d;
  logic sync2_q, sync2_d;
  logic prev_q, prev_d;
  logic rise_q, rise_d;
  logic fall_q, fall_d;

  ////////////////////////////////////////////////////////////////////
  // Only sync2 is looked at; sync1 may be metastable
  always_comb begin
    sync1_d = pin;
    sync2_d = sync1_q;
    prev_d = sync2_q;
    rise_d = sync2_q & ~prev_q;
    fall_d = ~sync2_q & prev_q;
  end

  // Registers; pin assumed low at reset, so no false edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign rise = rise_q;
  assign fall = fall_q;

endmodule : pcap1_edge

// >>> pcap1_mst.sv
/*
  Fieldbus master model: three reads in back-to-back cycles.
  Assumes the block answers each read one cycle after it is taken.
*/
`timescale 1ns/1ps

module pcap1_mst (
  // Clock
  input wire logic clk,
  // Read port of the block
  output logic rd_req,
  output pcap1_pkg::pcap1_addr_t rd_addr,
  input wire pcap1_pkg::pcap1_data_t rd_data,
  input wire logic rd_valid,
  input wire logic rd_err
);
  pcap1_pkg::pcap1_data_t rdat [3];
  logic rerr [3];
  logic vok;
  pcap1_pkg::pcap1_addr_t aq [3];

  // Idle bus shows a changed address, never the last one
  initial begin
    rd_req = 1'b0;
    rd_addr = 16'hffff;
  end

  // Count before position
  // Callers put the snapshot count ahead of the snapshot position
  task rd3(input pcap1_pkg::pcap1_addr_t a0, a1, a2);
    aq[0] = a0;
    aq[1] = a1;
    aq[2] = a2;
    vok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      if (i > 0) begin
        rdat[i-1] = rd_data;
        rerr[i-1] = rd_err;
        vok = vok & rd_valid;
      end
      if (i < 3) begin
        rd_req = 1'b1;
        rd_addr = aq[i];
      end else begin
        rd_req = 1'b0;
        rd_addr = ~aq[2];
      end
    end
  endtask : rd3
endmodule : pcap1_mst

// >>> pcap1_pkg.sv
/*
  Types for the capture input one block.
  Assumes pcap1_cfg.svh is on the include path.
*/
`include "pcap1_cfg.svh"

package pcap1_pkg;

  // Event counter and position words
  typedef logic [`PCAP1_CNT_W-1:0] pcap1_cnt_t;
  typedef logic signed [`PCAP1_POS_W-1:0] pcap1_pos_t;
  typedef logic [`PCAP1_DATA_W-1:0] pcap1_data_t;
  typedef logic [`PCAP1_ADDR_W-1:0] pcap1_addr_t;

  // Which parameter a read address selects
  typedef enum logic [3:0] {
    PCAP1_SEL_NONE,
    PCAP1_SEL_POS,
    PCAP1_SEL_TOTAL,
    PCAP1_SEL_SNAP_CNT,
    PCAP1_SEL_SNAP_POS,
    PCAP1_SEL_RISE_CNT,
    PCAP1_SEL_FALL_CNT,
    PCAP1_SEL_POS_RISE,
    PCAP1_SEL_POS_FALL
  } pcap1_sel_t;

endpackage : pcap1_pkg

// >>> pcap1_top.sv
/*
  Capture input one: position latches, event counters and the
  consistent snapshot pair, read as parameters by address.
  Assumes act_pos, cap_enable and the frame shift come from logic on
  clk; only the capture pin is asynchronous.
*/
`timescale 1ns/1ps
`include "pcap1_cfg.svh"

module pcap1_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Capture pin and its configuration
  input wire logic cap_pin,
  input wire logic cap_enable,
  input wire logic cap_on_rise,
  input wire logic cap_on_fall,
  // Motor position in user units
  input wire pcap1_pkg::pcap1_pos_t act_pos,
  // Position setting or reference movement: frame shift
  input wire logic frame_shift,
  input wire pcap1_pkg::pcap1_pos_t frame_delta,
  // Parameter read port
  input wire logic rd_req,
  input wire pcap1_pkg::pcap1_addr_t rd_addr,
  output pcap1_pkg::pcap1_data_t rd_data,
  output logic rd_valid,
  output logic rd_err,
  // Capture activity
  output logic cap_event
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Wrapping counter step
  function automatic pcap1_pkg::pcap1_cnt_t cnt_inc(
    input pcap1_pkg::pcap1_cnt_t v
  );
    cnt_inc = v + `PCAP1_CNT_ONE;
  endfunction : cnt_inc

  // Move a stored position into the new reference frame
  function automatic pcap1_pkg::pcap1_pos_t pos_move(
    input pcap1_pkg::pcap1_pos_t v,
    input pcap1_pkg::pcap1_pos_t delta
  );
    pos_move = v + delta;
  endfunction : pos_move

  // Address decode
  function automatic pcap1_pkg::pcap1_sel_t sel_of(
    input pcap1_pkg::pcap1_addr_t a
  );
    if (a == `PCAP1_ADDR_POS) begin
      sel_of = pcap1_pkg::PCAP1_SEL_POS;
    end else if (a == `PCAP1_ADDR_TOTAL) begin
      sel_of = pcap1_pkg::PCAP1_SEL_TOTAL;
    end else if (a == `PCAP1_ADDR_SNAP_CNT) begin
      sel_of = pcap1_pkg::PCAP1_SEL_SNAP_CNT;
    end else if (a == `PCAP1_ADDR_SNAP_POS) begin
      sel_of = pcap1_pkg::PCAP1_SEL_SNAP_POS;
    end else if (a == `PCAP1_ADDR_RISE_CNT) begin
      sel_of = pcap1_pkg::PCAP1_SEL_RISE_CNT;
    end else if (a == `PCAP1_ADDR_FALL_CNT) begin
      sel_of = pcap1_pkg::PCAP1_SEL_FALL_CNT;
    end else if (a == `PCAP1_ADDR_POS_RISE) begin
      sel_of = pcap1_pkg::PCAP1_SEL_POS_RISE;
    end else if (a == `PCAP1_ADDR_POS_FALL) begin
      sel_of = pcap1_pkg::PCAP1_SEL_POS_FALL;
    end else begin
      sel_of = pcap1_pkg::PCAP1_SEL_NONE;
    end
  endfunction : sel_of

  // Widen a counter into a data word, upper bits zero
  function automatic pcap1_pkg::pcap1_data_t cnt_word(
    input pcap1_pkg::pcap1_cnt_t v
  );
    cnt_word = {{(`PCAP1_DATA_W-`PCAP1_CNT_W){1'b0}}, v};
  endfunction : cnt_word

  ////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised pin

  logic pin_rise;
  logic pin_fall;

  pcap1_edge pcap1_edge_i (
    .clk(clk),
    .rst(rst),
    .pin(cap_pin),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////
  // Activation tracking and event qualification

  logic en_q, en_d;
  logic activate;
  logic ev_rise;
  logic ev_fall;
  logic ev_any;

  // Events count only once the input has been active a full cycle,
  // so the clear on activation never races a count
  always_comb begin
    en_d = cap_enable;
    activate = cap_enable & ~en_q;
    ev_rise = en_q & cap_enable & cap_on_rise & pin_rise;
    ev_fall = en_q & cap_enable & cap_on_fall & pin_fall;
    ev_any = ev_rise | ev_fall;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Event counters

  pcap1_pkg::pcap1_cnt_t total_q, total_d;
  pcap1_pkg::pcap1_cnt_t rise_cnt_q, rise_cnt_d;
  pcap1_pkg::pcap1_cnt_t fall_cnt_q, fall_cnt_d;

  always_comb begin
    total_d = total_q;
    rise_cnt_d = rise_cnt_q;
    fall_cnt_d = fall_cnt_q;
    if (activate) begin
      total_d = `PCAP1_CNT_RST;
      rise_cnt_d = `PCAP1_CNT_RST;
      fall_cnt_d = `PCAP1_CNT_RST;
    end else begin
      if (ev_any) begin
        total_d = cnt_inc(total_q);
      end
      if (ev_rise) begin
        rise_cnt_d = cnt_inc(rise_cnt_q);
      end
      if (ev_fall) begin
        fall_cnt_d = cnt_inc(fall_cnt_q);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      total_q <= `PCAP1_CNT_RST;
      rise_cnt_q <= `PCAP1_CNT_RST;
      fall_cnt_q <= `PCAP1_CNT_RST;
    end else begin
      total_q <= total_d;
      rise_cnt_q <= rise_cnt_d;
      fall_cnt_q <= fall_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Captured positions and snapshot

  pcap1_pkg::pcap1_pos_t pos_q, pos_d;
  pcap1_pkg::pcap1_pos_t pos_rise_q, pos_rise_d;
  pcap1_pkg::pcap1_pos_t pos_fall_q, pos_fall_d;
  pcap1_pkg::pcap1_pos_t snap_pos_q, snap_pos_d;
  pcap1_pkg::pcap1_sel_t req_sel;
  logic snap_take;

  // A capture in the shift cycle wins: act_pos is already in the new
  // frame, so shifting it again would double the delta
  always_comb begin
    req_sel = sel_of(rd_addr);
    snap_take = rd_req & (req_sel == pcap1_pkg::PCAP1_SEL_SNAP_CNT);
    pos_d = pos_q;
    pos_rise_d = pos_rise_q;
    pos_fall_d = pos_fall_q;
    snap_pos_d = snap_pos_q;
    if (frame_shift) begin
      pos_d = pos_move(pos_q, frame_delta);
      pos_rise_d = pos_move(pos_rise_q, frame_delta);
      pos_fall_d = pos_move(pos_fall_q, frame_delta);
      snap_pos_d = pos_move(snap_pos_q, frame_delta);
    end
    if (ev_any) begin
      pos_d = act_pos;
    end
    if (ev_rise) begin
      pos_rise_d = act_pos;
    end
    if (ev_fall) begin
      pos_fall_d = act_pos;
    end
    if (snap_take) begin
      snap_pos_d = frame_shift ? pos_move(pos_q, frame_delta) : pos_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_q <= `PCAP1_POS_RST;
      pos_rise_q <= `PCAP1_POS_RST;
      pos_fall_q <= `PCAP1_POS_RST;
      snap_pos_q <= `PCAP1_POS_RST;
    end else begin
      pos_q <= pos_d;
      pos_rise_q <= pos_rise_d;
      pos_fall_q <= pos_fall_d;
      snap_pos_q <= snap_pos_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read port: answer one cycle after the request

  pcap1_pkg::pcap1_data_t rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;
  logic rd_err_q, rd_err_d;
  logic cap_event_q, cap_event_d;

  // Values are those before this cycle's update, so the snapshot
  // counter and the copied position describe the same moment
  always_comb begin
    rd_valid_d = rd_req;
    rd_err_d = 1'b0;
    rd_data_d = `PCAP1_DATA_RST;
    cap_event_d = ev_any;
    if (rd_req) begin
      case (req_sel)
        pcap1_pkg::PCAP1_SEL_POS: begin
          rd_data_d = pos_q;
        end
        pcap1_pkg::PCAP1_SEL_TOTAL: begin
          rd_data_d = cnt_word(total_q);
        end
        pcap1_pkg::PCAP1_SEL_SNAP_CNT: begin
          rd_data_d = cnt_word(total_q);
        end
        pcap1_pkg::PCAP1_SEL_SNAP_POS: begin
          rd_data_d = snap_pos_q;
        end
        pcap1_pkg::PCAP1_SEL_RISE_CNT: begin
          rd_data_d = cnt_word(rise_cnt_q);
        end
        pcap1_pkg::PCAP1_SEL_FALL_CNT: begin
          rd_data_d = cnt_word(fall_cnt_q);
        end
        pcap1_pkg::PCAP1_SEL_POS_RISE: begin
          rd_data_d = pos_rise_q;
        end
        pcap1_pkg::PCAP1_SEL_POS_FALL: begin
          rd_data_d = pos_fall_q;
        end
        default: begin
          rd_err_d = 1'b1; // Unmapped address, data zero
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= `PCAP1_DATA_RST;
      rd_valid_q <= 1'b0;
      rd_err_q <= 1'b0;
      cap_event_q <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      rd_err_q <= rd_err_d;
      cap_event_q <= cap_event_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign rd_err = rd_err_q;
  assign cap_event = cap_event_q;

endmodule : pcap1_top

// >>> tb_pcap1_top.sv
/*
  Testbench for capture input one: table of reads, then hand tests.
  Assumes pcap1_cfg.svh on the include path; inputs move at negedge.
*/
`timescale 1ns/1ps
`include "pcap1_cfg.svh"

module tb_pcap1_top;
  typedef struct packed {
    logic [15:0] a;
    logic [31:0] d;
    logic e;
  } pcap1_row_t;
  logic clk, rst, cap_pin, cap_enable, cap_on_rise, cap_on_fall;
  logic frame_shift, rd_req, rd_valid, rd_err, cap_event;
  pcap1_pkg::pcap1_pos_t act_pos, frame_delta;
  pcap1_pkg::pcap1_addr_t rd_addr;
  pcap1_pkg::pcap1_data_t rd_data;
  int mismatches = 0;
  int samples_checked = 0;
  int ev_seen = 0;
  pcap1_row_t rows [9];
  localparam logic [31:0] PA = 32'hffff_ff00;
  localparam logic [31:0] PB = 32'h0000_1234;
  localparam logic [31:0] PC = 32'h0000_0077;

  pcap1_top pcap1_top_i (.clk(clk), .rst(rst), .cap_pin(cap_pin),
    .cap_enable(cap_enable), .cap_on_rise(cap_on_rise),
    .cap_on_fall(cap_on_fall), .act_pos(act_pos),
    .frame_shift(frame_shift), .frame_delta(frame_delta), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_err(rd_err), .cap_event(cap_event));
  pcap1_mst pcap1_mst_i (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Count event pulses at negedge, where the one-cycle pulse is settled
  always @(negedge clk) begin
    if (cap_event === 1'b1) begin
      ev_seen++;
    end
  end

  ////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Pin moves with a steady position; 8 cycles covers sync latency
  task edge_to(input logic lvl, input logic [31:0] pos);
    @(negedge clk);
    act_pos = pos;
    cap_pin = lvl;
    repeat (8) @(negedge clk);
  endtask : edge_to

  task rd1(input logic [15:0] a, input logic [31:0] d, input logic e);
    pcap1_mst_i.rd3(a, a, a);
    chk(pcap1_mst_i.rdat[0], d);
    chk({31'h0, pcap1_mst_i.rerr[0]}, {31'h0, e});
    chk({31'h0, pcap1_mst_i.vok}, 32'h1);
  endtask : rd1

  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    give_verdict;
  end

  ////////////////////////////////
  initial begin
    rst = 1'b1;
    {cap_pin, cap_enable, frame_shift} = 3'h0;
    {cap_on_rise, cap_on_fall} = 2'h3;
    act_pos = '0;
    frame_delta = 32'h0000_0010;
    // Count posedges: the clock's start from unknown can fake a negedge
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    cap_enable = 1'b1;
    edge_to(1'b1, PA);
    edge_to(1'b0, PB);
    rows = '{'{`PCAP1_ADDR_POS, PB, 1'b0}, '{`PCAP1_ADDR_TOTAL, 32'h2, 1'b0},
      '{`PCAP1_ADDR_RISE_CNT, 32'h1, 1'b0},
      '{`PCAP1_ADDR_FALL_CNT, 32'h1, 1'b0},
      '{`PCAP1_ADDR_POS_RISE, PA, 1'b0}, '{`PCAP1_ADDR_POS_FALL, PB, 1'b0},
      '{`PCAP1_ADDR_SNAP_CNT, 32'h2, 1'b0},
      '{`PCAP1_ADDR_SNAP_POS, PB, 1'b0}, '{16'h0a0e, 32'h0, 1'b1}};
    foreach (rows[i]) begin
      rd1(rows[i].a, rows[i].d, rows[i].e);
    end
    $display("table done");
    edge_to(1'b1, PC);
    rd1(`PCAP1_ADDR_SNAP_POS, PB, 1'b0);
    pcap1_mst_i.rd3(`PCAP1_ADDR_POS, `PCAP1_ADDR_SNAP_CNT,
      `PCAP1_ADDR_SNAP_POS);
    chk(pcap1_mst_i.rdat[1], 32'h3);
    chk(pcap1_mst_i.rdat[2], PC);
    $display("snapshot done");
    @(negedge clk);
    frame_shift = 1'b1;
    @(negedge clk);
    frame_shift = 1'b0;
    rd1(`PCAP1_ADDR_POS, 32'h0000_0087, 1'b0);
    rd1(`PCAP1_ADDR_POS_FALL, 32'h0000_1244, 1'b0);
    rd1(`PCAP1_ADDR_SNAP_POS, 32'h0000_0087, 1'b0);
    $display("shift done");
    // A real fall while inactive must not move the falling-edge position
    cap_enable = 1'b0;
    edge_to(1'b0, PA);
    cap_on_fall = 1'b0;
    cap_enable = 1'b1;
    edge_to(1'b1, PB);
    edge_to(1'b0, PC);
    rd1(`PCAP1_ADDR_TOTAL, 32'h1, 1'b0);
    rd1(`PCAP1_ADDR_FALL_CNT, 32'h0, 1'b0);
    rd1(`PCAP1_ADDR_RISE_CNT, 32'h1, 1'b0);
    rd1(`PCAP1_ADDR_POS_FALL, 32'h0000_1244, 1'b0);
    // Rising edges off, falling edges on
    {cap_on_rise, cap_on_fall} = 2'h1;
    edge_to(1'b1, PA);
    edge_to(1'b0, PB);
    rd1(`PCAP1_ADDR_POS_RISE, PB, 1'b0);
    rd1(`PCAP1_ADDR_POS_FALL, PB, 1'b0);
    rd1(`PCAP1_ADDR_TOTAL, 32'h2, 1'b0);
    rd1(`PCAP1_ADDR_RISE_CNT, 32'h1, 1'b0);
    chk(ev_seen, 32'h5);
    $display("activation done");
    // Mid-run reset; pin is low here, so no false edge at release
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd1(`PCAP1_ADDR_TOTAL, 32'h0, 1'b0);
    rd1(`PCAP1_ADDR_POS, 32'h0, 1'b0);
    rd1(`PCAP1_ADDR_SNAP_POS, 32'h0, 1'b0);
    $display("reset done");
    give_verdict;
  end
endmodule : tb_pcap1_top
